// ==== design/apo_pkg.sv ====
// package: constants for the attribute pixel output stage
package apo_pkg;
  // host port addresses
  localparam logic [15:0] PORT_INDEX_DATA  = 16'h03C0;
  localparam logic [15:0] PORT_DATA_READ   = 16'h03C1;
  localparam logic [15:0] PORT_STATUS_MONO = 16'h03BA;
  localparam logic [15:0] PORT_STATUS_CLR  = 16'h03DA;
  // register indices
  localparam logic [4:0] IDX_PLANE_ENABLE = 5'h12;
  localparam logic [4:0] IDX_PIXEL_SHIFT  = 5'h13;
  localparam logic [4:0] IDX_COLOUR_BANK  = 5'h14;
  // field positions
  localparam int ROUTE_LO   = 4;
  localparam int MODE_HI_SRC = 7;
  localparam int MODE_SPLIT = 5;
  // reset values
  localparam logic [5:0] PLANE_RESET = 6'h0F;
  localparam logic [3:0] SHIFT_RESET = 4'h0;
  localparam logic [3:0] BANK_RESET  = 4'h0;
  // panning limits
  localparam logic [3:0] NINE_DOT_ZERO = 4'h8;
  // underline gap begins this many dots before dot 8
  localparam logic [3:0] DASH_PERIOD = 4'h2;
  // line-graphics code range
  localparam logic [7:0] LINE_GFX_LO = 8'hC0;
  localparam logic [7:0] LINE_GFX_HI = 8'hDF;
  // pixel mode
  typedef enum logic [2:0] {
    APO_MODE_EIGHT = 3'b001,
    APO_MODE_NINE  = 3'b010,
    APO_MODE_256   = 3'b100
  } apo_mode_t;
endpackage

// ==== design/apo_fifo.sv ====
// file: parameterised valid/ready FIFO for pixel words
`timescale 1ns/1ps
module apo_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock, enable and reset
  input  wire logic             clk,
  input  wire logic             rstB,
  input  wire logic             ce,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  wire              doWr;
  wire              doRd;

  // handshake decode
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWr     = ce && inValid && inReady;
  assign doRd     = ce && outValid && outReady;

  // occupancy after this edge
  assign next_count = (doWr && !doRd) ? (AW+1)'(count + 1'b1) :
                      (doRd && !doWr) ? (AW+1)'(count - 1'b1) : count;

  // storage
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count   <= '0;
      inReady <= 1'b1;
    end else begin
      if (doWr) wrPtr <= AW'(wrPtr + 1'b1);
      if (doRd) rdPtr <= AW'(rdPtr + 1'b1);
      count   <= next_count;
      inReady <= (next_count != (AW+1)'(DEPTH)); // full flag from a flop
    end
  end
endmodule

// ==== design/apo_output_stage.sv ====
// file: attribute pixel output stage, host ports and DAC pixel path
// Operation
// [R01] index 12h plane enable: written via 03C0, read via 03C1
// [R02] bits 5:4 route colour bit pairs 2/0, 5/4, 3/1, 7/6 to status
// [R03] plane-enable bits 3:0 gate each memory colour plane
// [R04] index 13h panning: low four bits give left shift, upper zero
// [R05] nine-dot text: 0..7 shifts n+1, 8 shifts zero
// [R06] other non-256 modes: value 0..7 shifts that many pixels
// [R07] 256-colour: 0,2,4,6 shift 0..3; odd undefined
// [R08] index 14h colour select: bits 3:0, upper bits read zero
// [R09] mode bit7 zero: six palette bits plus select bits 3,2 on top
// [R10] mode bit7 one: palette 3:0 plus all four select bits
// [R11] 256-colour: memory attribute goes straight to the DAC
// [R12] mode bit5: line compare zeroes panning until vertical sync
// [R13] host disables interrupts, resets toggle, writes index, accesses
// [R14] host leaves palette alone in 256-colour mode
// [R15] host pans further via max value, start address, then 8 or 0
// [R16] underline solid in 8-dot, dashed in 9-dot except C0..DF
// [R17] writes flip index/data toggle; status read clears it
// [R18] mode bit7 picks palette or select bits 1,0 for colour 5,4
// [R19] reserved bits of the three registers read as zero
`timescale 1ns/1ps
module apo_output_stage #(
  parameter int FIFO_DEPTH = 16
) (
  // clock, enable, reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  // host io port
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioWr,
  input  wire logic        ioRd,
  input  wire logic [7:0]  ioWrData,
  output logic      [7:0]  ioRdData,
  // mode inputs from the rest of the attribute controller
  input  wire logic [7:0]  modeControl,
  input  wire logic        nineDotText,
  // crt timing controller events (foreign domain pins)
  input  wire logic        lineCompare,
  input  wire logic        vSync,
  // pixel input stream
  input  wire logic        pixValid,
  output logic             pixReady,
  input  wire logic [3:0]  planeBits,
  input  wire logic [5:0]  paletteBits,
  input  wire logic [7:0]  memAttr,
  input  wire logic        underlineOn,
  input  wire logic [7:0]  charCode,
  input  wire logic [3:0]  dotInChar,
  // outputs to dac and status
  output logic [3:0]       planeGated,
  output logic [3:0]       panShift,
  output logic             dacValid,
  input  wire logic        dacReady,
  output logic [7:0]       pixelColourBits,
  output logic [1:0]       statusPortColourRoute,
  output logic             underlineDot
);
  // reset release
  logic rstMeta, rstSync;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // pin synchronisers for crt events
  logic lcMeta, lcSync, vsMeta, vsSync;
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      lcMeta <= 1'b0;
      lcSync <= 1'b0;
      vsMeta <= 1'b0;
      vsSync <= 1'b0;
    end else if (clkEn) begin
      lcMeta <= lineCompare;
      lcSync <= lcMeta;
      vsMeta <= vSync;
      vsSync <= vsMeta;
    end
  end

  // registers and host state
  logic [5:0] planeEnable;
  logic [3:0] pixelShift;
  logic [3:0] colourBank;
  logic [4:0] attrIndex;
  logic       dataPhase;
  logic       panForcedZero;
  logic       vsPrev;

  // host decode
  wire wrPort   = clkEn && ioWr && (ioAddr == apo_pkg::PORT_INDEX_DATA);
  wire rdStatus = clkEn && ioRd &&
                  (ioAddr == apo_pkg::PORT_STATUS_MONO ||
                   ioAddr == apo_pkg::PORT_STATUS_CLR);
  wire rdData   = clkEn && ioRd && (ioAddr == apo_pkg::PORT_DATA_READ);
  wire wrData   = wrPort && dataPhase;
  wire vsRise   = vsSync && !vsPrev;

  // index/data toggle and register writes
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      planeEnable <= apo_pkg::PLANE_RESET;
      pixelShift  <= apo_pkg::SHIFT_RESET;
      colourBank  <= apo_pkg::BANK_RESET;
      attrIndex   <= 5'h00;
      dataPhase   <= 1'b0;
    end else begin
      if (rdStatus) dataPhase <= 1'b0;                   // R17
      else if (wrPort) dataPhase <= !dataPhase;           // R17
      if (wrPort && !dataPhase) attrIndex <= ioWrData[4:0];
      if (wrData && attrIndex == apo_pkg::IDX_PLANE_ENABLE)
        planeEnable <= ioWrData[5:0];                     // R01
      if (wrData && attrIndex == apo_pkg::IDX_PIXEL_SHIFT)
        pixelShift <= ioWrData[3:0];                      // R04
      if (wrData && attrIndex == apo_pkg::IDX_COLOUR_BANK)
        colourBank <= ioWrData[3:0];                      // R08
    end
  end

  // read mux, reserved bits zero
  logic [7:0] next_rdData;
  always_comb begin
    next_rdData = 8'h00;
    case (attrIndex)
      apo_pkg::IDX_PLANE_ENABLE: next_rdData = {2'b00, planeEnable}; // R19
      apo_pkg::IDX_PIXEL_SHIFT:  next_rdData = {4'h0, pixelShift};   // R19
      apo_pkg::IDX_COLOUR_BANK:  next_rdData = {4'h0, colourBank};   // R19
      default:                   next_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) ioRdData <= 8'h00;
    else if (rdData) ioRdData <= next_rdData;             // R01
  end

  // split-screen pan reset
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      panForcedZero <= 1'b0;
      vsPrev        <= 1'b0;
    end else if (clkEn) begin
      vsPrev <= vsSync;
      if (vsRise) panForcedZero <= 1'b0;                 // R12
      else if (lcSync && modeControl[apo_pkg::MODE_SPLIT])
        panForcedZero <= 1'b1;                            // R12
    end
  end

  // mode select
  apo_pkg::apo_mode_t mode;
  assign mode = modeControl[6] ? apo_pkg::APO_MODE_256 :
                nineDotText ? apo_pkg::APO_MODE_NINE :
                apo_pkg::APO_MODE_EIGHT;

  // pan value to pixel count
  function automatic logic [3:0] pan_pixels(input apo_pkg::apo_mode_t m,
                                            input logic [3:0] v);
    case (m)
      apo_pkg::APO_MODE_NINE:                              // R05
        pan_pixels = (v == apo_pkg::NINE_DOT_ZERO) ? 4'h0
                   : (v < apo_pkg::NINE_DOT_ZERO) ? 4'(v + 4'h1) : 4'h0;
      apo_pkg::APO_MODE_256: pan_pixels = {2'b00, v[2:1]}; // R07
      apo_pkg::APO_MODE_EIGHT: pan_pixels = {1'b0, v[2:0]}; // R06
      default: pan_pixels = 4'h0;
    endcase
  endfunction

  wire [3:0] effShift = panForcedZero ? 4'h0 : pixelShift; // R12

  // colour formation
  wire [3:0] gatedPlanes = planeBits & planeEnable[3:0];   // R03
  wire [1:0] hiPair = modeControl[apo_pkg::MODE_HI_SRC] ?
                      colourBank[1:0] : paletteBits[5:4];  // R18 R10
  wire [7:0] composed = {colourBank[3:2], hiPair,
                         paletteBits[3:0]};                // R09 R10
  wire [7:0] colourWord = (mode == apo_pkg::APO_MODE_256) ?
                          memAttr : composed;              // R11

  // underline pattern
  wire lineGfx = (charCode >= apo_pkg::LINE_GFX_LO) &&
                 (charCode <= apo_pkg::LINE_GFX_HI);
  wire dashGap = (dotInChar >= 4'(apo_pkg::NINE_DOT_ZERO -
                 apo_pkg::DASH_PERIOD));
  wire ulDot = underlineOn &&
               ((mode != apo_pkg::APO_MODE_NINE) || lineGfx ||
                !dashGap);                                 // R16

  // status route selection
  function automatic logic [1:0] route_pair(input logic [1:0] sel,
                                            input logic [7:0] p);
    case (sel)
      2'b00:   route_pair = {p[2], p[0]};                  // R02
      2'b01:   route_pair = {p[5], p[4]};
      2'b10:   route_pair = {p[3], p[1]};
      2'b11:   route_pair = {p[7], p[6]};
      default: route_pair = 2'b00;
    endcase
  endfunction

  // pixel fifo toward dac
  logic       fifoOutValid;
  logic [8:0] fifoOut;
  apo_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) uFifo (
    .clk      (ref_clk),
    .rstB     (rstSync),
    .ce       (clkEn),
    .inValid  (pixValid),
    .inReady  (pixReady),
    .inData   ({ulDot, colourWord}),
    .outValid (fifoOutValid),
    .outReady (!dacValid || dacReady),
    .outData  (fifoOut)
  );

  // registered outputs
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      dacValid              <= 1'b0;
      pixelColourBits       <= 8'h00;
      underlineDot          <= 1'b0;
      statusPortColourRoute <= 2'b00;
      planeGated            <= 4'h0;
      panShift              <= 4'h0;
    end else if (clkEn) begin
      if (!dacValid || dacReady) begin
        dacValid        <= fifoOutValid;
        pixelColourBits <= fifoOut[7:0];
        underlineDot    <= fifoOut[8];
      end
      statusPortColourRoute <= route_pair(
        planeEnable[apo_pkg::ROUTE_LO +: 2], pixelColourBits); // R02
      planeGated <= gatedPlanes;                                // R03
      panShift   <= pan_pixels(mode, effShift);                 // R04
    end
  end

  // checks: line compare seen while split reset armed, vsync not rising
  sequence s_line_hit;
    clkEn && lcSync && modeControl[apo_pkg::MODE_SPLIT] && !vsRise;
  endsequence

  // forced pan in a mode where a zero register value means no shift
  sequence s_forced_out;
    clkEn && panForcedZero && (mode != apo_pkg::APO_MODE_NINE);
  endsequence

  property p_toggle_clear;
    @(posedge ref_clk) disable iff (!rstSync)
      rdStatus |=> !dataPhase;
  endproperty
  a_toggle_clear: assert property (p_toggle_clear) // R17
    else $error("status read did not clear toggle");

  property p_toggle_flip;
    @(posedge ref_clk) disable iff (!rstSync)
      wrPort && !rdStatus |=> dataPhase != $past(dataPhase);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) // R17
    else $error("port write did not flip toggle");

  property p_split_set;
    @(posedge ref_clk) disable iff (!rstSync)
      s_line_hit |=> panForcedZero;
  endproperty
  a_split_set: assert property (p_split_set) // R12
    else $error("line compare did not force pan");

  property p_split_hold;
    @(posedge ref_clk) disable iff (!rstSync)
      s_forced_out |=> panShift == 4'h0;
  endproperty
  a_split_hold: assert property (p_split_hold) // R12
    else $error("pan not forced zero after line compare");

  property p_vs_release;
    @(posedge ref_clk) disable iff (!rstSync)
      clkEn && vsRise |=> !panForcedZero;
  endproperty
  a_vs_release: assert property (p_vs_release) // R12
    else $error("vsync did not release forced pan");

  property p_plane_gate;
    @(posedge ref_clk) disable iff (!rstSync)
      clkEn |=>
        planeGated == ($past(planeBits) & $past(planeEnable[3:0]));
  endproperty
  a_plane_gate: assert property (p_plane_gate) // R03
    else $error("plane gating wrong");

  property p_route_pair;
    @(posedge ref_clk) disable iff (!rstSync)
      clkEn && planeEnable[apo_pkg::ROUTE_LO +: 2] == 2'b01 |=>
        statusPortColourRoute == $past(pixelColourBits[5:4]);
  endproperty
  a_route_pair: assert property (p_route_pair) // R02
    else $error("status route pair wrong");

  property p_pack;
    @(posedge ref_clk) disable iff (!rstSync)
      mode != apo_pkg::APO_MODE_256 |->
        colourWord[7:6] == colourBank[3:2] &&
        colourWord[3:0] == paletteBits[3:0];
  endproperty
  a_pack: assert property (p_pack) // R09
    else $error("high colour bits not from colour select");
endmodule

// ==== tb/apo_dac_sink.sv ====
// file: colour dac model taking pixels at a settable pace
`timescale 1ns/1ps
module apo_dac_sink (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // pace: 0 prompt, 1 every other cycle, 2 stalled
  input  wire logic [1:0] pace,
  // pixel handshake
  input  wire logic       dacValid,
  output logic            dacReady,
  output int              taken
);
  logic phase;
  // ready pattern for the chosen pace
  assign dacReady = (pace == 2'h0) || (pace == 2'h1 && phase);
  // count pixels handed over
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 1'b0;
      taken <= 0;
    end else begin
      phase <= !phase;
      if (dacValid && dacReady) taken <= taken + 1;
    end
  end
endmodule

// ==== tb/apo_output_stage_tb_top.sv ====
// file: self-checking bench for the attribute pixel output stage
`timescale 1ns/1ps
module apo_output_stage_tb_top;
  typedef struct packed {
    logic [7:0] mc, pal, mem, bank, pe, pan, cc, dot;
    logic       nine;
    logic [7:0] col;
    logic [3:0] sh, pl;
    logic [1:0] rt;
    logic       ul;
  } apo_row_t;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic [15:0] ioAddr = 16'h0000;
  logic ioWr = 1'b0, ioRd = 1'b0, nineDotText = 1'b0, pixValid = 1'b0;
  logic lineCompare = 1'b0, vSync = 1'b0, underlineOn = 1'b1;
  logic [7:0] ioWrData = 8'h00, modeControl = 8'h00, memAttr = 8'h00;
  logic [7:0] charCode = 8'h00;
  logic [5:0] paletteBits = 6'h00;
  logic [3:0] planeBits = 4'h0, dotInChar = 4'h0;
  logic [1:0] pace = 2'h0;
  logic [7:0] ioRdData, pixelColourBits, v;
  logic [3:0] planeGated, panShift;
  logic [1:0] statusPortColourRoute;
  logic pixReady, dacValid, dacReady, underlineDot, ok;
  int taken, base, n, errCount = 0, cmpCount = 0, cyc = 0;
  apo_row_t r;
  // rows: 8-dot, bank source, 256, nine-dot gap, line gfx, max pans
  // inputs, then colour, shift, plane, route, underline expected
  apo_row_t rows [7] = '{
    '{8'h00, 8'h2A, 8'h00, 8'h0C, 8'h0F, 8'h05, 8'h41, 8'h07, 1'b0,
      8'hEA, 4'h5, 4'hA, 2'h0, 1'b1},
    '{8'h80, 8'h3F, 8'h00, 8'h09, 8'h1A, 8'h07, 8'h41, 8'h03, 1'b0,
      8'h9F, 4'h7, 4'hA, 2'h1, 1'b1},
    '{8'h40, 8'h15, 8'hC3, 8'h0F, 8'h25, 8'h06, 8'h41, 8'h00, 1'b0,
      8'hC3, 4'h3, 4'h5, 2'h1, 1'b1},
    '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h07, 8'hDF, 8'h06, 1'b1,
      8'h01, 4'h8, 4'h0, 2'h1, 1'b1},
    '{8'h00, 8'h15, 8'h00, 8'h04, 8'h33, 8'h08, 8'h41, 8'h07, 1'b1,
      8'h55, 4'h0, 4'h1, 2'h1, 1'b0},
    '{8'h80, 8'h2C, 8'h00, 8'h06, 8'h2C, 8'h03, 8'hC5, 8'h07, 1'b1,
      8'h6C, 4'h4, 4'hC, 2'h2, 1'b1},
    '{8'h00, 8'h3E, 8'h00, 8'h08, 8'h31, 8'h00, 8'h20, 8'h05, 1'b1,
      8'hBE, 4'h1, 4'h0, 2'h2, 1'b1}};

  apo_output_stage #(.FIFO_DEPTH(16)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .ioAddr(ioAddr),
    .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .modeControl(modeControl), .nineDotText(nineDotText),
    .lineCompare(lineCompare), .vSync(vSync), .pixValid(pixValid),
    .pixReady(pixReady), .planeBits(planeBits),
    .paletteBits(paletteBits), .memAttr(memAttr),
    .underlineOn(underlineOn), .charCode(charCode),
    .dotInChar(dotInChar), .planeGated(planeGated), .panShift(panShift),
    .dacValid(dacValid), .dacReady(dacReady),
    .pixelColourBits(pixelColourBits),
    .statusPortColourRoute(statusPortColourRoute),
    .underlineDot(underlineDot));
  apo_dac_sink dac (.ref_clk(ref_clk), .rst_b(rst_b), .pace(pace),
    .dacValid(dacValid), .dacReady(dacReady), .taken(taken));

  // clock and hang guard
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errCount++;
      testDone();
    end
  end

  // compare, host port cycles and verdict
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task io(input logic [15:0] a, input logic w, re, input logic [7:0] d);
    ioAddr <= a;
    ioWr <= w;
    ioRd <= re;
    ioWrData <= d;
    @(posedge ref_clk);
    ioWr <= 1'b0;
    ioRd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task o(input logic [7:0] d);
    io(apo_pkg::PORT_INDEX_DATA, 1'b1, 1'b0, d);
  endtask
  task clr();
    io(apo_pkg::PORT_STATUS_CLR, 1'b0, 1'b1, 8'h00);
  endtask
  task wr(input logic [4:0] i, input logic [7:0] d);
    clr();
    o({3'h1, i});
    o(d);
  endtask
  task rd(input logic [4:0] i);
    clr();
    o({3'h1, i});
    io(apo_pkg::PORT_DATA_READ, 1'b0, 1'b1, 8'h00);
    @(negedge ref_clk);
    v = ioRdData;
    @(posedge ref_clk);
  endtask
  task evt(input logic lc, vs, input logic [3:0] e);
    lineCompare <= lc;
    vSync <= vs;
    repeat (3) @(posedge ref_clk);
    lineCompare <= 1'b0;
    vSync <= 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("pan shift", {4'h0, e}, {4'h0, panShift});
    @(posedge ref_clk);
  endtask
  task testDone();
    $display("compares %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // reset, table rows, then the awkward cases
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(5'h12);
    chk("plane reset", {2'h0, apo_pkg::PLANE_RESET}, v);
    rd(5'h13);
    chk("shift reset", 8'h00, v);
    rd(5'h15);
    chk("unknown index", 8'h00, v);
    pixValid <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      modeControl <= r.mc;
      nineDotText <= r.nine;
      paletteBits <= r.pal[5:0];
      planeBits <= r.pal[3:0];
      memAttr <= r.mem;
      charCode <= r.cc;
      dotInChar <= r.dot[3:0];
      wr(5'h12, r.pe | 8'hC0);
      wr(5'h13, r.pan | 8'hF0);
      wr(5'h14, r.bank | 8'hF0);
      rd(5'h12);
      chk("plane rd", r.pe & 8'h3F, v);
      rd(5'h13);
      chk("shift rd", r.pan & 8'h0F, v);
      rd(5'h14);
      chk("bank rd", r.bank & 8'h0F, v);
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("colour", r.col, pixelColourBits);
      chk("shift", {4'h0, r.sh}, {4'h0, panShift});
      chk("route", {6'h00, r.rt}, {6'h00, statusPortColourRoute});
      chk("plane", {4'h0, r.pl}, {4'h0, planeGated});
      chk("underline", {7'h00, r.ul}, {7'h00, underlineDot});
      @(posedge ref_clk);
    end
    clr();
    o(8'h33);
    io(apo_pkg::PORT_DATA_READ, 1'b0, 1'b1, 8'h00);
    o(8'h02);
    o(8'h34);
    o(8'h05);
    rd(5'h13);
    chk("toggle shift", 8'h02, v);
    rd(5'h14);
    chk("toggle bank", 8'h05, v);
    modeControl <= 8'h20;
    nineDotText <= 1'b0;
    wr(5'h13, 8'h03);
    evt(1'b1, 1'b0, 4'h0);
    evt(1'b0, 1'b1, 4'h3);
    modeControl <= 8'h00;
    evt(1'b1, 1'b0, 4'h3);
    // pan past the maximum: max value, then the wrap value
    nineDotText <= 1'b1;
    wr(5'h13, 8'h07);
    evt(1'b0, 1'b0, 4'h8);
    wr(5'h13, {4'h0, apo_pkg::NINE_DOT_ZERO});
    evt(1'b0, 1'b0, 4'h0);
    // writes while the clock enable is low are ignored
    clkEn <= 1'b0;
    wr(5'h13, 8'h06);
    clkEn <= 1'b1;
    rd(5'h13);
    chk("frozen shift", 8'h08, v);
    // direct mode: palette left alone, memory attribute goes out
    modeControl <= 8'h40;
    memAttr <= 8'h5A;
    evt(1'b0, 1'b0, 4'h0);
    @(negedge ref_clk);
    chk("direct colour", 8'h5A, pixelColourBits);
    @(posedge ref_clk);
    pixValid <= 1'b0;
    repeat (20) @(posedge ref_clk);
    base = taken;
    pace <= 2'h2;
    pixValid <= 1'b1;
    n = 0;
    ok = 1'b1;
    while (ok && n < 40) begin
      @(negedge ref_clk);
      ok = pixReady;
      @(posedge ref_clk);
      if (ok) n++;
    end
    pixValid <= 1'b0;
    pace <= 2'h1;
    // sixteen fifo words plus the one held at the dac port
    chk("fill", 8'h11, 8'(n));
    repeat (100) @(posedge ref_clk);
    chk("drain", 8'(n), 8'(taken - base));
    testDone();
  end
endmodule
